// ---- core/trib_loop_pkg.sv ----
// constants, types and address decode for the tributary loopback control
// assumes a 16-bit register port with byte addresses
package trib_loop_pkg;

  // ==========================================================================
  // sizes
  localparam int PORT_CNT = 28;
  localparam int LOW_CNT = 16;
  localparam int HIGH_CNT = 12;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int G747_SKIP = 4;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] DIAG_LOW_ADDR = 8'h54;
  localparam logic [7:0] DIAG_HIGH_ADDR = 8'h56;
  localparam logic [7:0] CMD_LOW_ADDR = 8'h58;
  localparam logic [7:0] CMD_HIGH_ADDR = 8'h5A;
  localparam logic [7:0] STAT_LOW_ADDR = 8'h70;
  localparam logic [7:0] STAT_HIGH_ADDR = 8'h72;

  // ==========================================================================
  // reset values and masks
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [11:0] HIGH_RST = 12'h000;
  localparam logic [15:0] RD_IDLE = 16'h0000;
  localparam logic [27:0] PORT_RST = 28'h000_0000;
  localparam logic [27:0] G747_DEAD = 28'h888_8888;
  localparam logic [27:0] E3_DEAD = 28'hFFF_0000;
  localparam logic [3:0] HIGH_PAD = 4'h0;

  // ==========================================================================
  // register select
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_DIAG_LOW,
    SEL_DIAG_HIGH,
    SEL_CMD_LOW,
    SEL_CMD_HIGH,
    SEL_STAT_LOW,
    SEL_STAT_HIGH
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [7:0] addr);
    case (addr)
      DIAG_LOW_ADDR: decode_addr = SEL_DIAG_LOW;
      DIAG_HIGH_ADDR: decode_addr = SEL_DIAG_HIGH;
      CMD_LOW_ADDR: decode_addr = SEL_CMD_LOW;
      CMD_HIGH_ADDR: decode_addr = SEL_CMD_HIGH;
      STAT_LOW_ADDR: decode_addr = SEL_STAT_LOW;
      STAT_HIGH_ADDR: decode_addr = SEL_STAT_HIGH;
      default: decode_addr = SEL_NONE;
    endcase
  endfunction

endpackage

// ---- core/trib_loop_if.sv ----
// carrier between the control bank and the c3 stuffing generator
// assumes both ends share clk_sys
`timescale 1ns/1ps
`default_nettype none

interface trib_loop_if;
  logic [27:0] cmd;
  logic [27:0] c12_bit;
  logic [27:0] c3_bit;

  modport ctl (
    output cmd,
    output c12_bit,
    input c3_bit
  );

  modport fmt (
    input cmd,
    input c12_bit,
    output c3_bit
  );
endinterface

`default_nettype wire

// ---- core/c3_stuff_gen.sv ----
// per-port c3 stuffing-control bit for the t2 transmit formatters
// assumes c1/c2 come from formatter logic on clk_sys
`timescale 1ns/1ps
`default_nettype none

module c3_stuff_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // carrier
  trib_loop_if.fmt c3_io
);

  // ==========================================================================
  // c3 generation
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      c3_io.c3_bit <= trib_loop_pkg::PORT_RST;
    end else begin
      // inverted while the command stands, plain copy otherwise
      c3_io.c3_bit <= c3_io.c12_bit ^ c3_io.cmd;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // the edge at reset release still shows the reset value of c3
  a_c3_follow_off: assert property (
    $past(rst_b) && ($past(c3_io.cmd) == 28'h000_0000)
    |-> (c3_io.c3_bit == $past(c3_io.c12_bit)))
    else $error("c3 differs from c1/c2 with no command");

  a_c3_invert_on: assert property (
    $past(c3_io.cmd[0]) |-> (c3_io.c3_bit[0] != $past(c3_io.c12_bit[0])))
    else $error("c3 not inverted under command");

  a_c3_persist: assert property (
    (c3_io.cmd[3] [*6]) |=> (c3_io.c3_bit[3] == !$past(c3_io.c12_bit[3])))
    else $error("c3 inversion lapsed while command held");

endmodule // c3_stuff_gen

`default_nettype wire

// ---- core/trib_loop_ctl.sv ----
// tributary loopback control: diagnostic loopback and far-end command bank
// assumes tx pins are asynchronous; line data, c1/c2 and modes on clk_sys
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module trib_loop_ctl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wr_data,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  output logic [15:0] reg_rd_data,
  // mode configuration
  input wire logic e3_mode,
  input wire logic g747_mode,
  input wire logic lowspeed_loop_timed,
  // tributary transmit pins
  input wire logic [27:0] tx_clk_pin,
  input wire logic [27:0] tx_data_pin,
  // demultiplexed receive side
  input wire logic [27:0] rx_clk_line,
  input wire logic [27:0] rx_data_line,
  output logic [27:0] rx_clk_out,
  output logic [27:0] rx_data_out,
  output logic [27:0] loop_active,
  // t2 formatters
  input wire logic [27:0] c12_bit,
  output logic [27:0] c3_bit
);

  // ==========================================================================
  // port liveness
  function automatic logic port_is_live(input int idx, input logic e3,
                                        input logic g747);
    logic dead_g747;
    logic dead_e3;
    dead_g747 = g747 && ((idx % trib_loop_pkg::G747_SKIP) ==
                         (trib_loop_pkg::G747_SKIP - 1));
    dead_e3 = e3 && (idx >= trib_loop_pkg::LOW_CNT);
    port_is_live = !(dead_g747 || dead_e3);
  endfunction

  // ==========================================================================
  // registers
  logic [15:0] diag_low_r;
  logic [11:0] diag_high_r;
  logic [15:0] cmd_low_r;
  logic [11:0] cmd_high_r;
  logic [15:0] rd_data_r;
  logic [15:0] rd_data_nxt;
  trib_loop_pkg::reg_sel_t wr_sel;
  trib_loop_pkg::reg_sel_t rd_sel;

  assign wr_sel = trib_loop_pkg::decode_addr(reg_addr);
  assign rd_sel = trib_loop_pkg::decode_addr(reg_addr);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      diag_low_r <= trib_loop_pkg::LOW_RST;
      diag_high_r <= trib_loop_pkg::HIGH_RST;
    end else if (reg_wr_stb) begin
      case (wr_sel)
        trib_loop_pkg::SEL_DIAG_LOW: diag_low_r <= reg_wr_data;
        // bits 15:12 have no storage
        trib_loop_pkg::SEL_DIAG_HIGH:
          diag_high_r <= reg_wr_data[11:0];
        default: diag_low_r <= diag_low_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_low_r <= trib_loop_pkg::LOW_RST;
      cmd_high_r <= trib_loop_pkg::HIGH_RST;
    end else if (reg_wr_stb) begin
      case (wr_sel)
        trib_loop_pkg::SEL_CMD_LOW: cmd_low_r <= reg_wr_data;
        trib_loop_pkg::SEL_CMD_HIGH: cmd_high_r <= reg_wr_data[11:0];
        default: cmd_low_r <= cmd_low_r;
      endcase
    end
  end

  // ==========================================================================
  // read path, data valid only in the cycle after the strobe
  always_comb begin
    rd_data_nxt = trib_loop_pkg::RD_IDLE;
    if (reg_rd_stb) begin
      case (rd_sel)
        trib_loop_pkg::SEL_DIAG_LOW: rd_data_nxt = diag_low_r;
        trib_loop_pkg::SEL_DIAG_HIGH:
          rd_data_nxt = {trib_loop_pkg::HIGH_PAD, diag_high_r};
        trib_loop_pkg::SEL_CMD_LOW: rd_data_nxt = cmd_low_r;
        trib_loop_pkg::SEL_CMD_HIGH:
          rd_data_nxt = {trib_loop_pkg::HIGH_PAD, cmd_high_r};
        trib_loop_pkg::SEL_STAT_LOW: rd_data_nxt = loop_active[15:0];
        trib_loop_pkg::SEL_STAT_HIGH:
          rd_data_nxt = {trib_loop_pkg::HIGH_PAD, loop_active[27:16]};
        default: rd_data_nxt = trib_loop_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= trib_loop_pkg::RD_IDLE;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign reg_rd_data = rd_data_r;

  // ==========================================================================
  // tx pin synchronisers, change taken once stages two and three agree
  logic [27:0] clk_s1_r;
  logic [27:0] clk_s2_r;
  logic [27:0] clk_s3_r;
  logic [27:0] dat_s1_r;
  logic [27:0] dat_s2_r;
  logic [27:0] dat_s3_r;
  logic [27:0] tx_clk_filt_r;
  logic [27:0] tx_dat_filt_r;
  logic [27:0] live_mask;
  logic [27:0] eff_loop;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      clk_s1_r <= trib_loop_pkg::PORT_RST;
      clk_s2_r <= trib_loop_pkg::PORT_RST;
      clk_s3_r <= trib_loop_pkg::PORT_RST;
      dat_s1_r <= trib_loop_pkg::PORT_RST;
      dat_s2_r <= trib_loop_pkg::PORT_RST;
      dat_s3_r <= trib_loop_pkg::PORT_RST;
    end else begin
      clk_s1_r <= tx_clk_pin;
      clk_s2_r <= clk_s1_r;
      clk_s3_r <= clk_s2_r;
      dat_s1_r <= tx_data_pin;
      dat_s2_r <= dat_s1_r;
      dat_s3_r <= dat_s2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < trib_loop_pkg::PORT_CNT; gi++) begin : g_port
      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          tx_clk_filt_r[gi] <= 1'b0;
          tx_dat_filt_r[gi] <= 1'b0;
        end else begin
          if (clk_s2_r[gi] == clk_s3_r[gi]) begin
            tx_clk_filt_r[gi] <= clk_s3_r[gi];
          end
          if (dat_s2_r[gi] == dat_s3_r[gi]) begin
            tx_dat_filt_r[gi] <= dat_s3_r[gi];
          end
        end
      end
      // dead ports in e3 and g747 ignore their enable
      assign live_mask[gi] = port_is_live(gi, e3_mode, g747_mode);
    end
  endgenerate

  // bit n of the joined set drives port n+1
  assign eff_loop = {diag_high_r, diag_low_r} & live_mask;

  // ==========================================================================
  // loopback selection
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_data_out <= trib_loop_pkg::PORT_RST;
      loop_active <= trib_loop_pkg::PORT_RST;
    end else begin
      rx_data_out <= (eff_loop & tx_dat_filt_r) |
                     (~eff_loop & rx_data_line);
      loop_active <= eff_loop;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rx_clk_out <= trib_loop_pkg::PORT_RST;
    end else if (lowspeed_loop_timed) begin
      // loop timed: receive keeps its own clock
      rx_clk_out <= rx_clk_line;
    end else begin
      rx_clk_out <= (eff_loop & tx_clk_filt_r) | (~eff_loop & rx_clk_line);
    end
  end

  // ==========================================================================
  // far-end command to the c3 generator
  trib_loop_if c3_io ();

  // commands pass unmasked; host keeps them clear in e3/g747
  assign c3_io.cmd = {cmd_high_r, cmd_low_r};
  assign c3_io.c12_bit = c12_bit;
  assign c3_bit = c3_io.c3_bit;

  c3_stuff_gen u_c3_stuff_gen (
    .clk_sys (clk_sys),
    .rst_b (rst_b),
    .c3_io (c3_io.fmt)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_diag_write_read: assert property (
    (reg_wr_stb && reg_addr == trib_loop_pkg::DIAG_LOW_ADDR) ##1
    (reg_rd_stb && !reg_wr_stb && reg_addr == trib_loop_pkg::DIAG_LOW_ADDR)
    |=> (reg_rd_data == $past(reg_wr_data, 2)))
    else $error("diag enable low readback mismatch");

  a_high_pad_zero: assert property (
    $past(reg_rd_stb) && ($past(reg_addr) == trib_loop_pkg::DIAG_HIGH_ADDR ||
    $past(reg_addr) == trib_loop_pkg::CMD_HIGH_ADDR)
    |-> (reg_rd_data[15:12] == 4'h0))
    else $error("unused high bits read non-zero");

  a_rd_one_cycle: assert property (
    !$past(reg_rd_stb) |-> (reg_rd_data == 16'h0000))
    else $error("read data outside its cycle");

  a_data_looped: assert property (
    $past(eff_loop[0]) |-> (rx_data_out[0] == $past(tx_dat_filt_r[0])))
    else $error("port 1 data not looped");

  a_data_passed: assert property (
    $past(rst_b) && !$past(eff_loop[1])
    |-> (rx_data_out[1] == $past(rx_data_line[1])))
    else $error("port 2 data looped while off");

  a_port2_map: assert property (
    (reg_wr_stb && reg_addr == trib_loop_pkg::DIAG_LOW_ADDR &&
    reg_wr_data[1]) ##1
    !(reg_wr_stb && reg_addr == trib_loop_pkg::DIAG_LOW_ADDR)
    |=> loop_active[1])
    else $error("enable bit 1 did not activate port 2");

  a_timed_clock: assert property (
    $past(lowspeed_loop_timed && eff_loop[5])
    |-> (rx_clk_out[5] == $past(rx_clk_line[5])))
    else $error("clock looped in loop-timed mode");

  a_g747_dead: assert property (
    $past(g747_mode) |-> ((loop_active[15:0] & 16'h8888) == 16'h0000))
    else $error("dead g747 port looped");

  a_g747_high_dead: assert property (
    $past(g747_mode) |-> ((loop_active & trib_loop_pkg::G747_DEAD) ==
    28'h000_0000))
    else $error("dead g747 port 20/24/28 looped");

  a_e3_dead: assert property (
    $past(e3_mode) |-> (loop_active[27:16] == 12'h000))
    else $error("port above 16 looped in e3");

  a_port18_map: assert property (
    $past(diag_high_r[1] && !e3_mode) |-> loop_active[17])
    else $error("port 18 enable not honoured");

  a_cmd_port2: assert property (
    (reg_wr_stb && reg_addr == trib_loop_pkg::CMD_LOW_ADDR &&
    reg_wr_data[1]) |=> ##1 (c3_bit[1] != $past(c12_bit[1])))
    else $error("port 2 command did not invert c3");

  a_cmd_port18: assert property (
    (reg_wr_stb && reg_addr == trib_loop_pkg::CMD_HIGH_ADDR &&
    reg_wr_data[1]) |=> ##1 (c3_bit[17] != $past(c12_bit[17])))
    else $error("port 18 command did not invert c3");

  a_cmd_clear: assert property (
    (reg_wr_stb && reg_addr == trib_loop_pkg::CMD_LOW_ADDR &&
    !reg_wr_data[0]) |=> ##1 (c3_bit[0] == $past(c12_bit[0])))
    else $error("cleared command still inverts c3");

  c_loop_port1: cover property (eff_loop[0] ##1 loop_active[0]);
  c_loop_timed: cover property (lowspeed_loop_timed && eff_loop[3]);
  c_cmd_high: cover property (cmd_high_r[11] ##2 c3_bit[27] != c12_bit[27]);
  c_e3_masked: cover property (e3_mode && diag_high_r[0]);

endmodule // trib_loop_ctl

`default_nettype wire

// ---- sim/tb_tributary_loopback_control.sv ----
// self-checking bench for the tributary loopback control bank
// assumes trib_loop_pkg compiled first; assertions live in the design files
`timescale 1ns/1ps
`default_nettype none

module tb_tributary_loopback_control;

  // ==========================================================================
  // signals
  logic clk_sys;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [15:0] reg_wr_data;
  logic reg_wr_stb;
  logic reg_rd_stb;
  logic [15:0] reg_rd_data;
  logic e3_mode;
  logic g747_mode;
  logic lowspeed_loop_timed;
  logic [27:0] tx_clk_pin;
  logic [27:0] tx_data_pin;
  logic [27:0] rx_clk_line;
  logic [27:0] rx_data_line;
  logic [27:0] rx_clk_out;
  logic [27:0] rx_data_out;
  logic [27:0] loop_active;
  logic [27:0] c12_bit;
  logic [27:0] c3_bit;
  int num_errors;
  int total_checks;
  logic [15:0] sh [4];
  logic [7:0] addr_tab [4];
  logic [15:0] rd_val;
  logic [15:0] d;
  logic [27:0] en;
  logic [27:0] eff;
  logic [27:0] cmd;
  logic [27:0] v;

  trib_loop_ctl trib_loop_ctl_inst (
    .clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
    .reg_rd_data(reg_rd_data),
    .e3_mode(e3_mode), .g747_mode(g747_mode),
    .lowspeed_loop_timed(lowspeed_loop_timed),
    .tx_clk_pin(tx_clk_pin), .tx_data_pin(tx_data_pin),
    .rx_clk_line(rx_clk_line), .rx_data_line(rx_data_line),
    .rx_clk_out(rx_clk_out), .rx_data_out(rx_data_out),
    .loop_active(loop_active), .c12_bit(c12_bit), .c3_bit(c3_bit)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ==========================================================================
  // helpers
  function automatic logic [27:0] live(input logic e3, input logic g);
    int p;
    live = 28'h000_0000;
    for (p = 1; p <= 28; p++) begin
      live[p-1] = !((g && (p % 4 == 0)) || (e3 && p >= 17));
    end
  endfunction

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] wd);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= wd;
    reg_wr_stb <= 1'b1;
    @(posedge clk_sys);
    reg_wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] rdv);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge clk_sys);
    reg_rd_stb <= 1'b0;
    #1;
    rdv = reg_rd_data;
  endtask

  // write then read with no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] wd,
                       output logic [15:0] rdv);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= wd;
    reg_wr_stb <= 1'b1;
    @(posedge clk_sys);
    reg_wr_stb <= 1'b0;
    reg_rd_stb <= 1'b1;
    @(posedge clk_sys);
    reg_rd_stb <= 1'b0;
    #1;
    rdv = reg_rd_data;
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end

  // ==========================================================================
  // tests
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wr_data = 16'h0000;
    reg_wr_stb = 1'b0;
    reg_rd_stb = 1'b0;
    e3_mode = 1'b0;
    g747_mode = 1'b0;
    lowspeed_loop_timed = 1'b0;
    tx_clk_pin = 28'h000_0000;
    tx_data_pin = 28'h000_0000;
    rx_clk_line = 28'h000_0000;
    rx_data_line = 28'h000_0000;
    c12_bit = 28'h000_0000;
    num_errors = 0;
    total_checks = 0;
    addr_tab = '{trib_loop_pkg::DIAG_LOW_ADDR, trib_loop_pkg::DIAG_HIGH_ADDR,
                 trib_loop_pkg::CMD_LOW_ADDR, trib_loop_pkg::CMD_HIGH_ADDR};
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    void'($urandom(51));
    // reset values, then random write/read with high padding masked
    for (int i = 0; i < 4; i++) begin
      rd(addr_tab[i], rd_val);
      check({12'h000, rd_val}, 28'h000_0000);
    end
    for (int n = 0; n < 5; n++) begin
      for (int i = 0; i < 4; i++) begin
        d = (n == 0) ? 16'hFFFF : 16'($urandom);
        sh[i] = (i % 2 == 1) ? (d & 16'h0FFF) : d;
        if (n % 2 == 1) begin
          wr_rd(addr_tab[i], d, rd_val);
        end else begin
          wr(addr_tab[i], d);
          rd(addr_tab[i], rd_val);
        end
        check({12'h000, rd_val}, {12'h000, sh[i]});
      end
    end
    // unmapped place and read-only status
    wr(8'h5C, 16'hA5A5);
    rd(8'h5C, rd_val);
    check({12'h000, rd_val}, 28'h000_0000);
    wr(trib_loop_pkg::STAT_HIGH_ADDR, 16'hFFFF);
    // stray writes must leave the enables alone
    rd(addr_tab[0], rd_val);
    check({12'h000, rd_val}, {12'h000, sh[0]});
    // commands cleared before any mode is set
    wr(addr_tab[2], 16'h0000);
    wr(addr_tab[3], 16'h0000);
    // diagnostic loopback: corner modes first, then random
    for (int k = 0; k < 16; k++) begin
      d = 16'($urandom);
      wr(addr_tab[0], (k < 4) ? 16'hFFFF : d);
      sh[0] = (k < 4) ? 16'hFFFF : d;
      d = 16'($urandom);
      wr(addr_tab[1], (k < 4) ? 16'hFFFF : d);
      sh[1] = (k < 4) ? 16'h0FFF : (d & 16'h0FFF);
      @(posedge clk_sys);
      e3_mode <= (k < 4) ? k[1] : 1'($urandom);
      g747_mode <= (k < 4) ? k[0] : 1'($urandom);
      lowspeed_loop_timed <= (k < 4) ? 1'b0 : 1'($urandom);
      tx_clk_pin <= 28'($urandom);
      tx_data_pin <= 28'($urandom);
      rx_clk_line <= 28'($urandom);
      rx_data_line <= 28'($urandom);
      repeat (8) @(posedge clk_sys);
      #1;
      en = {sh[1][11:0], sh[0]};
      eff = en & live(e3_mode, g747_mode);
      check(loop_active, eff);
      check(rx_data_out, (eff & tx_data_pin) | (~eff & rx_data_line));
      check(rx_clk_out, lowspeed_loop_timed ? rx_clk_line :
            ((eff & tx_clk_pin) | (~eff & rx_clk_line)));
      rd(trib_loop_pkg::STAT_LOW_ADDR, rd_val);
      check({12'h000, rd_val}, {12'h000, eff[15:0]});
      rd(trib_loop_pkg::STAT_HIGH_ADDR, rd_val);
      check({12'h000, rd_val}, {16'h0000, eff[27:16]});
    end
    // far-end command: modes kept off while commands are used
    @(posedge clk_sys);
    e3_mode <= 1'b0;
    g747_mode <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      d = (k == 0) ? 16'hFFFF : ((k == 1) ? 16'h0000 : 16'($urandom));
      wr(addr_tab[2], d);
      sh[2] = d;
      d = (k == 0) ? 16'hFFFF : ((k == 1) ? 16'h0000 : 16'($urandom));
      wr(addr_tab[3], d);
      sh[3] = d & 16'h0FFF;
      cmd = {sh[3][11:0], sh[2]};
      repeat (6) begin
        v = 28'($urandom);
        @(posedge clk_sys);
        c12_bit <= v;
        @(posedge clk_sys);
        #1;
        check(c3_bit, v ^ cmd);
      end
    end
    // second reset mid-run
    @(posedge clk_sys);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(c3_bit, 28'h000_0000);
    check(loop_active, 28'h000_0000);
    @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(addr_tab[i], rd_val);
      check({12'h000, rd_val}, 28'h000_0000);
    end
    summarize();
  end

endmodule // tb_tributary_loopback_control

`default_nettype wire
